// ### swdcu_host_model.sv
// behavioural debug host adapter: shifts command bits in and read data out
`timescale 1ns/100ps
module swdcu_host_model (
   input  wire logic clk_i,
   input  wire logic pin_tx_valid_i,
   input  wire logic pin_tx_bit_i,
   output logic      pin_bit_valid_o,
   output logic      pin_bit_o,
   output logic      pin_tx_ready_o
);
   int slow;
   // idle pin at start, host answers promptly until told otherwise
   initial begin
      pin_bit_valid_o = 1'b0;
      pin_bit_o       = 1'b0;
      pin_tx_ready_o  = 1'b0;
      slow            = 0;
   end
   // one bit a cycle, msb first; a released line shows the inverse level
   task automatic send(input logic [15:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         @(negedge clk_i);
         pin_bit_valid_o = 1'b1;
         pin_bit_o       = v[i];
      end
      @(negedge clk_i);
      pin_bit_valid_o = 1'b0;
      pin_bit_o       = ~pin_bit_o;
   endtask : send
   // take 16 bits msb first, stalling slow cycles before each one
   task automatic recv(output logic [15:0] d);
      d = 16'h0000;
      for (int w = 0; w < 200 && pin_tx_valid_i !== 1'b1; w++) @(negedge clk_i);
      for (int i = 0; i < 16; i++) begin
         repeat (slow) @(negedge clk_i) pin_tx_ready_o = 1'b0;
         @(negedge clk_i);
         d              = {d[14:0], pin_tx_bit_i};
         pin_tx_ready_o = 1'b1;
      end
      @(negedge clk_i);
      pin_tx_ready_o = 1'b0;
   endtask : recv
endmodule : swdcu_host_model

// ### swdcu_pkg.sv
// constants and types shared by the single-wire debug command unit
package swdcu_pkg;
   // hardware command opcodes
   localparam logic [7:0] OP_HALT     = 8'h90;
   localparam logic [7:0] OP_ACK_ON   = 8'hD5;
   localparam logic [7:0] OP_ACK_OFF  = 8'hD6;
   localparam logic [7:0] OP_RD8_IN   = 8'hE4;
   localparam logic [7:0] OP_RD16_IN  = 8'hEC;
   localparam logic [7:0] OP_RD8_OUT  = 8'hE0;
   localparam logic [7:0] OP_RD16_OUT = 8'hE8;
   localparam logic [7:0] OP_WR8_IN   = 8'hC4;
   localparam logic [7:0] OP_WR16_IN  = 8'hCC;
   localparam logic [7:0] OP_WR8_OUT  = 8'hC0;
   localparam logic [7:0] OP_WR16_OUT = 8'hC8;
   // firmware command opcodes recognised for status tracking (values arbitrary)
   localparam logic [7:0] OP_FW_STEP  = 8'h10;
   localparam logic [7:0] OP_FW_TAG_AND_GO_CMD = 8'h18;
   // status/control bit positions
   localparam int BIT_ENABLE = 7;
   localparam int BIT_ACTIVE = 6;
   localparam int BIT_TAG    = 5;
   localparam int BIT_SDV    = 4;
   localparam int BIT_STEP   = 3;
   localparam logic [7:0] STS_RESET = 8'h00;
   // debug window in the memory map
   localparam logic [15:0] WIN_BASE = 16'hFF00;
   localparam logic [15:0] WIN_TOP  = 16'hFFFF;
   // tagging starts this many cycles after the tag bit is written
   localparam int          TAG_DELAY_CYC = 16;
   localparam logic [4:0]  TAG_DELAY     = 5'h10;
   localparam logic [4:0]  CNT_ZERO      = 5'h00;
   // field lengths in bits on the pin
   localparam logic [5:0]  LEN_OP   = 6'h08;
   localparam logic [5:0]  LEN_WORD = 6'h10;
   typedef enum logic [2:0] {
      ST_OP    = 3'b000,
      ST_ADDR  = 3'b001,
      ST_WDATA = 3'b010,
      ST_MEM   = 3'b011,
      ST_RDATA = 3'b100,
      ST_HALTW = 3'b101,
      ST_TAG   = 3'b110
   } swdcu_state_type;
endpackage : swdcu_pkg

// ### swdcu_top.sv
// single-wire debug command unit: pin shifter, command decoder, status register
`timescale 1ns/100ps
module swdcu_top (
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        pin_bit_valid_i,   // one received bit from the pin decoder
   input  wire logic        pin_bit_i,
   input  wire logic        pin_tx_ready_i,    // pin encoder takes a bit this cycle
   output logic             pin_tx_valid_o,
   output logic             pin_tx_bit_o,
   output logic             ack_pulse_o,       // completion pulse request to the pin
   input  wire logic        special_mode_i,
   input  wire logic        secure_mode_i,
   input  wire logic        nvm_checks_done_i,
   input  wire logic        halt_entered_i,    // core reached active halt
   input  wire logic        fw_exit_store_i,   // firmware store clearing debug_active
   input  wire logic        fw_data_phase_i,   // firmware read/write data phase done
   output logic             halt_req_o,
   output logic             tagging_o,
   output logic             mem_req_o,
   output logic             mem_we_o,
   output logic             mem_byte_o,
   output logic             mem_map_in_o,      // debug resources override for this cycle
   output logic [15:0]      mem_addr_o,
   output logic [15:0]      mem_wdata_o,
   input  wire logic        mem_done_i,
   input  wire logic [15:0] mem_rdata_i,
   output logic             window_visible_o,
   output logic [7:0]       status_o
);
   import swdcu_pkg::*;

   swdcu_state_type state_reg, state_next;
   logic [15:0] shift_reg, shift_next;
   logic [5:0]  cnt_reg, cnt_next;
   logic [7:0]  op_reg, op_next;
   logic [15:0] addr_reg, addr_next;
   logic [7:0]  sts_reg, sts_next;
   logic        hs_reg, hs_next;
   logic [4:0]  tag_reg, tag_next;
   logic        ack_reg, ack_next;
   logic        req_reg, req_next;
   logic        halt_reg, halt_next;
   logic        en_seen_reg, en_seen_next;

   logic        is_read, is_write, is_byte, map_in;
   logic [15:0] rd_field;
   always_comb begin
      is_read  = (op_reg[7:5] == 3'b111);
      is_write = (op_reg[7:5] == 3'b110) && (op_reg[1:0] == 2'b00);
      is_byte  = ~op_reg[3];
      map_in   = op_reg[2];
      // even byte in high half, odd byte in low half
      if (is_byte && addr_reg[0]) begin
         rd_field = {8'h00, mem_rdata_i[7:0]};
      end else if (is_byte) begin
         rd_field = {mem_rdata_i[15:8], 8'h00};
      end else begin
         rd_field = mem_rdata_i;
      end
   end

   // command sequencer: all fields shift msb first over the one pin
   always_comb begin
      state_next   = state_reg;
      shift_next   = shift_reg;
      cnt_next     = cnt_reg;
      op_next      = op_reg;
      addr_next    = addr_reg;
      sts_next     = sts_reg;
      hs_next      = hs_reg;
      tag_next     = tag_reg;
      ack_next     = 1'b0;
      req_next     = 1'b0;
      halt_next    = halt_reg;
      en_seen_next = en_seen_reg;
      // enable comes up by itself in special mode, gated by checks when secure
      if (!en_seen_reg && special_mode_i && (!secure_mode_i || nvm_checks_done_i)) begin
         sts_next[BIT_ENABLE] = 1'b1;
         en_seen_next         = 1'b1;
      end
      if (fw_data_phase_i && sts_reg[BIT_ACTIVE]) begin
         sts_next[BIT_SDV] = 1'b1;
      end
      if (fw_exit_store_i) begin
         sts_next[BIT_ACTIVE] = 1'b0;
         sts_next[BIT_SDV]    = 1'b0;
      end
      case (state_reg)
         ST_OP: begin
            if (pin_bit_valid_i) begin
               shift_next = {shift_reg[14:0], pin_bit_i};
               cnt_next   = cnt_reg + 6'h01;
               if (cnt_reg == LEN_OP - 6'h01) begin
                  op_next  = {shift_reg[6:0], pin_bit_i};
                  cnt_next = 6'h00;
                  sts_next[BIT_SDV] = 1'b0;
                  // step flag survives only back-to-back steps
                  sts_next[BIT_STEP] = ({shift_reg[6:0], pin_bit_i} == OP_FW_STEP)
                                       && sts_reg[BIT_ACTIVE];
                  case ({shift_reg[6:0], pin_bit_i})
                     OP_HALT: begin
                        if (sts_reg[BIT_ENABLE]) begin
                           halt_next  = 1'b1;
                           state_next = ST_HALTW;
                        end
                     end
                     OP_ACK_ON: begin
                        hs_next  = 1'b1;
                        ack_next = 1'b1;
                     end
                     OP_ACK_OFF: hs_next = 1'b0;
                     OP_FW_TAG_AND_GO_CMD: begin
                        if (sts_reg[BIT_ACTIVE]) begin
                           sts_next[BIT_TAG]    = 1'b1;
                           sts_next[BIT_ACTIVE] = 1'b0;
                           tag_next             = TAG_DELAY;
                           state_next           = ST_TAG; // no pulse here
                        end
                     end
                     OP_RD8_IN, OP_RD16_IN, OP_RD8_OUT, OP_RD16_OUT,
                     OP_WR8_IN, OP_WR16_IN, OP_WR8_OUT, OP_WR16_OUT:
                        state_next = ST_ADDR;
                     default: ;
                  endcase
               end
            end
         end
         ST_ADDR: begin
            if (pin_bit_valid_i) begin
               shift_next = {shift_reg[14:0], pin_bit_i};
               cnt_next   = cnt_reg + 6'h01;
               if (cnt_reg == LEN_WORD - 6'h01) begin
                  addr_next  = {shift_reg[14:0], pin_bit_i};
                  cnt_next   = 6'h00;
                  state_next = is_write ? ST_WDATA : ST_MEM;
                  req_next   = ~is_write;
               end
            end
         end
         ST_WDATA: begin
            if (pin_bit_valid_i) begin
               shift_next = {shift_reg[14:0], pin_bit_i};
               cnt_next   = cnt_reg + 6'h01;
               if (cnt_reg == LEN_WORD - 6'h01) begin
                  cnt_next   = 6'h00;
                  state_next = ST_MEM;
                  req_next   = 1'b1;
               end
            end
         end
         ST_MEM: begin
            if (mem_done_i) begin
               ack_next = hs_reg;
               if (is_read) begin
                  shift_next = rd_field;
                  state_next = ST_RDATA;
               end else begin
                  state_next = ST_OP;
               end
            end
         end
         ST_RDATA: begin
            if (pin_tx_ready_i) begin
               shift_next = {shift_reg[14:0], 1'b0}; // msb out first
               cnt_next   = cnt_reg + 6'h01;
               if (cnt_reg == LEN_WORD - 6'h01) begin
                  cnt_next   = 6'h00;
                  state_next = ST_OP;
               end
            end
         end
         ST_HALTW: begin
            if (halt_entered_i) begin
               halt_next            = 1'b0;
               sts_next[BIT_ACTIVE] = 1'b1;
               sts_next[BIT_TAG]    = 1'b0;
               ack_next             = hs_reg;
               state_next           = ST_OP;
            end
         end
         ST_TAG: begin
            // serial reception stops for the whole tag state, delay included; only re-entry ends it
            if (tag_reg != CNT_ZERO) begin
               tag_next = tag_reg - 5'h01;
            end
            if (halt_entered_i) begin
               sts_next[BIT_ACTIVE] = 1'b1;
               sts_next[BIT_TAG]    = 1'b0;
               tag_next             = CNT_ZERO;
               state_next           = ST_OP;
            end
         end
         default: state_next = ST_OP;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         state_reg   <= ST_OP;
         shift_reg   <= 16'h0000;
         cnt_reg     <= 6'h00;
         op_reg      <= 8'h00;
         addr_reg    <= 16'h0000;
         sts_reg     <= STS_RESET;
         hs_reg      <= 1'b0;
         tag_reg     <= 5'h00;
         ack_reg     <= 1'b0;
         req_reg     <= 1'b0;
         halt_reg    <= 1'b0;
         en_seen_reg <= 1'b0;
      end else begin
         state_reg   <= state_next;
         shift_reg   <= shift_next;
         cnt_reg     <= cnt_next;
         op_reg      <= op_next;
         addr_reg    <= addr_next;
         sts_reg     <= sts_next;
         hs_reg      <= hs_next;
         tag_reg     <= tag_next;
         ack_reg     <= ack_next;
         req_reg     <= req_next;
         halt_reg    <= halt_next;
         en_seen_reg <= en_seen_next;
      end
   end

   // memory request is a one-cycle strobe; map-in lasts only that cycle
   assign mem_req_o        = req_reg;
   assign mem_we_o         = is_write;
   assign mem_byte_o       = is_byte;
   assign mem_map_in_o     = req_reg & map_in;
   assign mem_addr_o       = addr_reg;
   assign mem_wdata_o      = shift_reg;
   assign pin_tx_valid_o   = (state_reg == ST_RDATA);
   assign pin_tx_bit_o     = shift_reg[15];
   assign ack_pulse_o      = ack_reg;
   assign halt_req_o       = halt_reg;
   assign tagging_o        = (state_reg == ST_TAG) && (tag_reg == CNT_ZERO);
   assign window_visible_o = sts_reg[BIT_ACTIVE];
   assign status_o         = sts_reg;

   // checks
   chk_halt_gated: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $rose(halt_reg) |-> $past(sts_reg[BIT_ENABLE]))
      else $error("halt requested while debug disabled");
   chk_ack_on_pulse: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (state_reg == ST_OP && pin_bit_valid_i && cnt_reg == 6'h07
       && {shift_reg[6:0], pin_bit_i} == OP_ACK_ON) |=> ack_reg)
      else $error("no pulse after handshake on");
   chk_ack_off_quiet: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      ack_reg |-> hs_reg)
      else $error("pulse while handshake off");
   chk_mapin_once: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      mem_map_in_o |=> !mem_map_in_o)
      else $error("map-in held past one cycle");
   // sixteen quiet cycles after the tag bit rises, then tagging takes the pin
   chk_tag_delay: assert property (@(posedge clk_i) disable iff (!rst_b_i || halt_entered_i)
      $rose(sts_reg[BIT_TAG]) |-> !tagging_o [*8] ##1 !tagging_o [*8] ##1 tagging_o)
      else $error("tagging delay wrong");
   // debug entry drops the tag bit, whether it came from the halt wait or the tag state
   chk_tag_entry_clr: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (halt_entered_i && (state_reg == ST_HALTW || state_reg == ST_TAG))
      |=> !sts_reg[BIT_TAG])
      else $error("tag bit kept over debug entry");
   // enable only rises out of special mode, and when secure only after the checks
   chk_secure_gate: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $rose(sts_reg[BIT_ENABLE])
      |-> $past(special_mode_i && (!secure_mode_i || nvm_checks_done_i)))
      else $error("debug enable set too early");
   // the exit store wins over a same-cycle data phase
   chk_sdv_exit: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      fw_exit_store_i |=> !sts_reg[BIT_SDV])
      else $error("shift data valid kept over exit");
   // handshake off is silent and takes effect at once
   chk_ack_off_cmd: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (state_reg == ST_OP && pin_bit_valid_i && cnt_reg == LEN_OP - 6'h01
       && {shift_reg[6:0], pin_bit_i} == OP_ACK_OFF) |=> (!ack_reg && !hs_reg))
      else $error("handshake off answered or ignored");
   // the step flag can only come up while firmware commands may run
   chk_step_active: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $rose(sts_reg[BIT_STEP]) |-> $past(sts_reg[BIT_ACTIVE]))
      else $error("step flag set outside debug mode");
   // an odd byte read leaves the high half of the field empty
   chk_byte_lane: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (state_reg == ST_MEM && mem_done_i && is_read && is_byte && addr_reg[0])
      |=> (shift_reg[15:8] == 8'h00))
      else $error("odd byte on the wrong lane");
   chk_tag_no_ack: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (state_reg == ST_TAG) |-> !ack_reg)
      else $error("pulse during tagging");
   chk_window_act: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      $rose(sts_reg[BIT_ACTIVE]) |-> $past(halt_entered_i))
      else $error("debug_active set without entry");
   chk_write_ack: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      (state_reg == ST_MEM && mem_done_i && hs_reg) |=> ack_reg)
      else $error("missing completion pulse");
   cov_halt: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(sts_reg[BIT_ACTIVE]));
   cov_read: cover property (@(posedge clk_i) disable iff (!rst_b_i) $fell(pin_tx_valid_o));
   cov_write: cover property (@(posedge clk_i) disable iff (!rst_b_i) mem_req_o && mem_we_o);
   cov_tagging: cover property (@(posedge clk_i) disable iff (!rst_b_i) $rose(tagging_o));
endmodule : swdcu_top

// ### swdcu_top_tb.sv
// self-checking bench of the single-wire debug command unit
`timescale 1ns/100ps
module swdcu_top_tb;
   import swdcu_pkg::*;
   logic        clk_i = 1'b0, rst_b_i, special_mode_i, halt_entered_i, mem_done_i;
   logic        fw_exit_store_i, fw_data_phase_i, pin_bit_valid_i, pin_bit_i;
   logic        pin_tx_ready_i, pin_tx_valid_o, pin_tx_bit_o, ack_pulse_o, halt_req_o;
   logic        tagging_o, mem_req_o, mem_we_o, mem_byte_o, mem_map_in_o, window_visible_o;
   logic [15:0] mem_rdata_i, mem_addr_o, mem_wdata_o, word, c_addr, c_wdata;
   logic [7:0]  status_o;
   logic [31:0] lfsr;
   logic [2:0]  c_ctl;
   logic        c_seen, secure_mode_i, nvm_checks_done_i;
   int          fails, n_compared, acks, mcnt, a0, k;
   localparam logic [7:0] OPS [8] = '{OP_RD8_IN, OP_RD16_IN, OP_RD8_OUT, OP_RD16_OUT,
                                      OP_WR8_IN, OP_WR16_IN, OP_WR8_OUT, OP_WR16_OUT};
   swdcu_top DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .pin_bit_valid_i(pin_bit_valid_i),
      .pin_bit_i(pin_bit_i), .pin_tx_ready_i(pin_tx_ready_i), .pin_tx_valid_o(pin_tx_valid_o),
      .pin_tx_bit_o(pin_tx_bit_o), .ack_pulse_o(ack_pulse_o), .special_mode_i(special_mode_i),
      .secure_mode_i(secure_mode_i), .nvm_checks_done_i(nvm_checks_done_i),
      .halt_entered_i(halt_entered_i),
      .fw_exit_store_i(fw_exit_store_i), .fw_data_phase_i(fw_data_phase_i),
      .halt_req_o(halt_req_o), .tagging_o(tagging_o), .mem_req_o(mem_req_o),
      .mem_we_o(mem_we_o), .mem_byte_o(mem_byte_o), .mem_map_in_o(mem_map_in_o),
      .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_done_i(mem_done_i),
      .mem_rdata_i(mem_rdata_i), .window_visible_o(window_visible_o), .status_o(status_o));
   swdcu_host_model host (.clk_i(clk_i), .pin_tx_valid_i(pin_tx_valid_o),
      .pin_tx_bit_i(pin_tx_bit_o), .pin_bit_valid_o(pin_bit_valid_i), .pin_bit_o(pin_bit_i),
      .pin_tx_ready_o(pin_tx_ready_i));
   // 100 MHz clock
   always #5 clk_i = ~clk_i;
   task automatic end_of_test;
      if (fails == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_of_test
   task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("Error %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp16
   task automatic cmp1(input logic got, input logic exp);
      cmp16({15'h0000, got}, {15'h0000, exp});
   endtask : cmp1
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction : lfsr_next
   // write, byte and mapped-in flags follow from the opcode pattern
   function automatic logic [2:0] exp_ctl(input logic [7:0] op);
      return {~op[5], ~op[3], op[2]};
   endfunction : exp_ctl
   // only the addressed half of a byte read is defined
   function automatic logic [15:0] exp_mask(input logic [7:0] op, input logic [15:0] a);
      return op[3] ? 16'hFFFF : (a[0] ? 16'h00FF : 16'hFF00);
   endfunction : exp_mask
   task automatic pulse(ref logic s);
      @(negedge clk_i) s = 1'b1;
      @(negedge clk_i) s = 1'b0;
      repeat (3) @(negedge clk_i);
   endtask : pulse
   task automatic do_reset(input logic sp);
      rst_b_i        = 1'b0;
      special_mode_i = sp;
      repeat (16) @(negedge clk_i);
      rst_b_i = 1'b1;
      repeat (2) @(negedge clk_i);
   endtask : do_reset
   // one memory command with random address and data
   task automatic rw(input logic [7:0] op, input logic hs);
      logic [15:0] a, d, got;
      lfsr = lfsr_next(lfsr);
      a    = lfsr[15:0];
      if (op[3]) a[0] = 1'b0;
      lfsr   = lfsr_next(lfsr);
      d      = lfsr[15:0];
      word   = lfsr[31:16];
      a0     = acks;
      c_seen = 1'b0;
      host.send({8'h00, op}, 8);
      host.send(a, 16);
      if (!op[5]) host.send(d, 16);
      if (op[5]) host.recv(got);
      else repeat (8) @(negedge clk_i);
      repeat (3) @(negedge clk_i);
      cmp1(c_seen, 1'b1);
      cmp16({13'h0000, c_ctl}, {13'h0000, exp_ctl(op)});
      cmp16(c_addr, a);
      if (op[5]) cmp16(got & exp_mask(op, a), word & exp_mask(op, a));
      else cmp16(c_wdata, d);
      cmp16(16'(acks - a0), {15'h0000, hs});
   endtask : rw
   // memory partner answers after 1..3 cycles; data lines show the inverse of word when idle
   always @(negedge clk_i) begin
      mem_done_i  <= 1'b0;
      mem_rdata_i <= ~word;
      if (rst_b_i === 1'b1) begin
         cmp1(mem_map_in_o & ~mem_req_o, 1'b0);
         if (ack_pulse_o === 1'b1) acks++;
         if (mem_req_o === 1'b1) begin
            c_seen  = 1'b1;
            c_ctl   = {mem_we_o, mem_byte_o, mem_map_in_o};
            c_addr  = mem_addr_o;
            c_wdata = mem_wdata_o;
            mcnt    = 1 + lfsr[1:0] % 3;
         end else if (mcnt > 0) begin
            mcnt--;
            if (mcnt == 0) begin
               mem_done_i  <= 1'b1;
               mem_rdata_i <= word;
            end
         end
      end
   end
   // watchdog: the whole sequence needs only about a thousand cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      fails++;
      end_of_test();
   end
   // main sequence
   initial begin
      {halt_entered_i, fw_exit_store_i, fw_data_phase_i, mem_done_i} = 4'h0;
      {secure_mode_i, nvm_checks_done_i} = 2'h0;
      fails      = 0;
      n_compared = 0;
      acks       = 0;
      mcnt       = 0;
      {mem_rdata_i, word, c_seen, lfsr} = {16'h0000, 16'h0000, 1'b0, 32'h0001_5C28};
      do_reset(1'b0);
      cmp16({8'h00, status_o}, 16'h0000);
      for (int r = 0; r < 2; r++) begin
         host.slow = 2 * r;
         if (r == 1) begin
            a0 = acks;
            host.send({8'h00, OP_ACK_ON}, 8);
            repeat (4) @(negedge clk_i);
            cmp16(16'(acks - a0), 16'h0001);
         end
         foreach (OPS[i]) rw(OPS[i], r[0]);
      end
      a0 = acks;
      host.send({8'h00, OP_ACK_OFF}, 8);
      host.send({8'h00, OP_HALT}, 8);
      repeat (20) @(negedge clk_i);
      cmp16(16'(acks - a0), 16'h0000);
      cmp1(halt_req_o, 1'b0);
      do_reset(1'b1);
      cmp1(status_o[BIT_ENABLE], 1'b1);
      host.send({8'h00, OP_ACK_ON}, 8);
      host.send({8'h00, OP_HALT}, 8);
      repeat (3) @(negedge clk_i);
      cmp1(halt_req_o, 1'b1);
      a0 = acks;
      pulse(halt_entered_i);
      cmp16(16'(acks - a0), 16'h0001);
      cmp1(status_o[BIT_ACTIVE] & window_visible_o, 1'b1);
      host.send({8'h00, OP_FW_STEP}, 8);
      host.send({8'h00, OP_FW_STEP}, 8);
      repeat (2) @(negedge clk_i);
      cmp1(status_o[BIT_STEP], 1'b1);
      pulse(fw_data_phase_i);
      cmp1(status_o[BIT_SDV], 1'b1);
      a0 = acks;
      host.send({8'h00, OP_FW_TAG_AND_GO_CMD}, 8);
      for (k = 0; k < 40 && tagging_o !== 1'b1; k++) @(negedge clk_i);
      cmp1(k >= 13 && k <= 18, 1'b1);
      cmp16({13'h0000, status_o[BIT_TAG:BIT_STEP]}, 16'h0004);
      cmp16(16'(acks - a0), 16'h0000);
      pulse(halt_entered_i);
      cmp1(status_o[BIT_TAG] | tagging_o, 1'b0);
      pulse(fw_exit_store_i);
      cmp1(status_o[BIT_ACTIVE] | window_visible_o, 1'b0);
      // secure part: enable waits for the memory checks
      secure_mode_i = 1'b1;
      do_reset(1'b1);
      cmp1(status_o[BIT_ENABLE], 1'b0);
      nvm_checks_done_i = 1'b1;
      repeat (2) @(negedge clk_i);
      cmp1(status_o[BIT_ENABLE], 1'b1);
      end_of_test();
   end
endmodule : swdcu_top_tb
